// ---- logic/ctc_console_channel.sv ----
`timescale 1ns/1ps
module ctc_console_channel import ctc_pkg::*; #(
  parameter logic [15:0] DEV_ID = DEV_ID_DEFAULT
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        cmd_valid_in,
  input  wire logic [5:0]  cmd_func_in,
  input  wire logic        cmd_chan_in,
  input  wire logic [23:0] cmd_data_in,
  input  wire logic        paper_tape_in,
  input  wire logic        int_allowed_in,
  input  wire logic        kbd_valid_in,
  input  wire logic [7:0]  kbd_char_in,
  input  wire logic        kbd_break_in,
  input  wire logic        prt_ready_in,
  input  wire logic        dma_ack_in,
  input  wire logic [7:0]  dma_rdata_in,
  output logic             rsp_valid_out,
  output logic [15:0]      rsp_data_out,
  output logic             busy_out,
  output logic             proc_indicator_out,
  output logic             irq_out,
  output logic             prt_valid_out,
  output logic [7:0]       prt_char_out,
  output logic             dma_req_out,
  output logic             dma_we_out,
  output logic [23:0]      dma_addr_out,
  output logic [7:0]       dma_wdata_out
);

  ctc_state_type state_r, state_nxt;
  logic [15:0]   task_r, cfg_a_r, cfg_b_r, range_r, init_range_r;
  logic [23:0]   addr_r;
  logic [3:0]    lines_r;
  logic [6:0]    col_r;
  logic [7:0]    char_r;
  logic          esc_r, attn_pend_r, st_attn_r, st_par_r, st_cc2_r, st_cc3_r;
  logic          cls_valid, is_back, is_cancel, is_home, is_escape, par_err;
  logic [7:0]    cls_char;
  logic [15:0]   rsp_nxt;

  // Output commands are refused while an order runs
  wire logic       cmd_idle  = cmd_valid_in & ~busy_out;
  wire logic       ld_task   = cmd_idle & (cmd_func_in == FC_TASK_OUT);
  wire logic       ld_cfg_a  = cmd_idle & (cmd_func_in == FC_CFG_A_OUT);
  wire logic       ld_cfg_b  = cmd_idle & (cmd_func_in == FC_CFG_B_OUT);
  wire logic       ld_addr   = cmd_idle & (cmd_func_in == FC_ADDR_OUT);
  wire logic       ld_range  = cmd_idle & (cmd_func_in == FC_RANGE_OUT);
  wire logic       st_read   = cmd_valid_in & (cmd_func_in == FC_STATUS_IN);
  wire logic       prt_fire  = prt_valid_out & prt_ready_in;
  wire logic       dma_fire  = dma_req_out & dma_ack_in;
  wire logic       rd_ev     = (state_r == S_RD_WAIT) & cls_valid;
  wire logic       ev_cancel = rd_ev & is_cancel;
  wire logic       ev_home   = rd_ev & is_home;
  wire logic       ev_back   = rd_ev & is_back & ~ev_cancel & ~ev_home;
  wire logic       ev_esc    = rd_ev & is_escape & ~is_back & ~ev_cancel & ~ev_home;
  wire logic       ev_data   = rd_ev & ~is_back & ~is_cancel & ~is_home & ~is_escape;
  wire logic       can_back  = (range_r != init_range_r);
  wire logic       is_cr     = (dma_rdata_in[6:0] == CR_CHAR[6:0]);
  wire logic       drop_char = (col_r >= LINE_LEN) & ~is_cr;
  wire logic       eight_bit = task_r[TB_EIGHT_BIT];
  wire logic       keep_attn = attn_pend_r & ~task_r[TB_ATTN_DISCARD];
  wire logic       in_print  = (state_r == S_RD_ECHO) | (state_r == S_WR_PRT) |
                               (state_r == S_WR_LF) | (state_r == S_HOME);
  wire logic       in_dma    = (state_r == S_RD_DMA) | (state_r == S_WR_DMA);
  // Range zero may skip the home character; other read ends always send it
  wire ctc_state_type end_st = task_r[TB_NO_HOME] ? S_DONE : S_HOME;
  wire logic [7:0] raw_prt   = (state_r == S_WR_LF) ? LF_CHAR :
                               (state_r == S_HOME) ? cfg_b_r[15:8] : char_r;
  wire logic [7:0] prt_nxt   = eight_bit ? raw_prt : ctc_even_par(raw_prt);

  ctc_char_class u_class (
    .ref_clk_in     (ref_clk_in),
    .rst_n_in       (rst_n_in),
    .kbd_valid_in   (kbd_valid_in),
    .kbd_char_in    (kbd_char_in),
    .seven_bit_in   (~eight_bit),
    .check_en_in    (~task_r[TB_NO_CHECK]),
    .escape_in      (esc_r),
    .cc1_in         (cfg_a_r[15:8]),
    .cc2_in         (cfg_a_r[7:0]),
    .cc3_in         (cfg_b_r[15:8]),
    .cc4_in         (cfg_b_r[7:0]),
    .cls_valid_out  (cls_valid),
    .cls_char_out   (cls_char),
    .is_back_out    (is_back),
    .is_cancel_out  (is_cancel),
    .is_home_out    (is_home),
    .is_escape_out  (is_escape),
    .parity_err_out (par_err)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (ld_range && cmd_chan_in) begin
          state_nxt = (task_r[3:0] != 4'h0) ? S_WR_LF : S_WR_DMA;
        end else if (ld_range) begin
          state_nxt = keep_attn ? S_RD_DMA : S_RD_WAIT;
        end
      end
      S_RD_WAIT: begin
        if (ev_cancel || ev_home) begin
          state_nxt = S_HOME;
        end else if (ev_data) begin
          state_nxt = S_RD_DMA;
        end
      end
      S_RD_DMA: begin
        if (dma_fire) begin
          state_nxt = task_r[TB_ECHO] ? S_RD_ECHO : ((range_r == 16'h0001) ? end_st : S_RD_WAIT);
        end
      end
      S_RD_ECHO: begin
        if (prt_fire) begin
          state_nxt = (range_r == 16'h0000) ? end_st : S_RD_WAIT;
        end
      end
      S_WR_LF: begin
        if (prt_fire && lines_r == 4'h1) begin
          state_nxt = S_WR_DMA;
        end
      end
      S_WR_DMA: begin
        if (dma_fire && drop_char) begin
          state_nxt = (range_r == 16'h0001) ? end_st : S_WR_DMA;
        end else if (dma_fire) begin
          state_nxt = S_WR_PRT;
        end
      end
      S_WR_PRT: begin
        if (prt_fire) begin
          state_nxt = (range_r == 16'h0000) ? end_st : S_WR_DMA;
        end
      end
      S_HOME: begin
        if (prt_fire) begin
          state_nxt = S_DONE;
        end
      end
      S_DONE: begin
        state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // No protection gate on the address readbacks; any caller sees them
  always_comb begin
    unique case (cmd_func_in)
      FC_DEV_ID:    rsp_nxt = DEV_ID;
      FC_BYTE_ADDR: rsp_nxt = addr_r[15:0];
      FC_MOD_ADDR:  rsp_nxt = {8'h00, addr_r[23:16]};
      FC_RANGE_IN:  rsp_nxt = range_r;
      FC_CFG_A_IN:  rsp_nxt = cfg_a_r;
      FC_CFG_B_IN:  rsp_nxt = cfg_b_r;
      FC_STATUS_IN: begin
        rsp_nxt = WORD_RST;
        rsp_nxt[ST_ATTN]     = st_attn_r;
        rsp_nxt[ST_PARITY]   = st_par_r;
        rsp_nxt[ST_TERM_CC2] = st_cc2_r;
        rsp_nxt[ST_TERM_CC3] = st_cc3_r;
      end
      default:      rsp_nxt = WORD_RST;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r            <= S_IDLE;
      busy_out           <= 1'b0;
      irq_out            <= 1'b0;
      rsp_valid_out      <= 1'b0;
      rsp_data_out       <= WORD_RST;
      proc_indicator_out <= 1'b0;
      prt_valid_out      <= 1'b0;
      prt_char_out       <= 8'h00;
      dma_req_out        <= 1'b0;
      dma_we_out         <= 1'b0;
      dma_addr_out       <= ADDR_RST;
      dma_wdata_out      <= 8'h00;
    end else begin
      state_r            <= state_nxt;
      busy_out           <= ld_range | (busy_out & (state_r != S_DONE));
      irq_out            <= (state_r == S_DONE) & int_allowed_in;
      rsp_valid_out      <= cmd_valid_in & ~cmd_func_in[0];
      rsp_data_out       <= rsp_nxt;
      proc_indicator_out <= st_read ? busy_out : proc_indicator_out;
      prt_valid_out      <= in_print & ~prt_fire;
      prt_char_out       <= prt_nxt;
      dma_req_out        <= in_dma & ~dma_fire;
      dma_we_out         <= (state_r == S_RD_DMA);
      dma_addr_out       <= addr_r;
      dma_wdata_out      <= char_r;
    end
  end

  // Configuration lives across console orders; a paper tape order replaces it
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      task_r  <= WORD_RST;
      cfg_a_r <= WORD_RST;
      cfg_b_r <= WORD_RST;
    end else begin
      task_r  <= ld_task ? cmd_data_in[15:0] : task_r;
      cfg_a_r <= paper_tape_in ? WORD_RST : (ld_cfg_a ? cmd_data_in[15:0] : cfg_a_r);
      cfg_b_r <= paper_tape_in ? WORD_RST : (ld_cfg_b ? cmd_data_in[15:0] : cfg_b_r);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_r       <= ADDR_RST;
      range_r      <= WORD_RST;
      init_range_r <= WORD_RST;
    end else if (ld_addr) begin
      addr_r <= cmd_data_in;
    end else if (ld_range) begin
      range_r      <= cmd_data_in[15:0];
      init_range_r <= cmd_data_in[15:0];
    end else if (dma_fire) begin
      addr_r  <= addr_r + 24'h00_0001;
      range_r <= range_r - 16'h0001;
    end else if (ev_back && can_back) begin
      addr_r  <= addr_r - 24'h00_0001;
      range_r <= range_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      char_r  <= 8'h00;
      esc_r   <= 1'b0;
      lines_r <= 4'h0;
      col_r   <= 7'h00;
    end else begin
      if (ld_range && !cmd_chan_in) begin
        char_r <= ATTN_CHAR;
      end else if (ev_data) begin
        char_r <= cls_char;
      end else if (dma_fire && state_r == S_WR_DMA) begin
        char_r <= dma_rdata_in;
      end
      esc_r   <= ev_esc | (esc_r & ~ev_data & ~ld_range);
      lines_r <= ld_range ? task_r[3:0] : lines_r - {3'h0, prt_fire & (state_r == S_WR_LF)};
      if ((prt_fire && state_r == S_HOME) || (dma_fire && state_r == S_WR_DMA && is_cr)) begin
        col_r <= 7'h00;
      end else if (dma_fire && state_r == S_WR_DMA && !drop_char) begin
        col_r <= col_r + 7'h01;
      end
    end
  end

  // Set wins over the clear on every sticky status bit
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      attn_pend_r <= 1'b0;
      st_attn_r   <= 1'b0;
      st_par_r    <= 1'b0;
      st_cc2_r    <= 1'b0;
      st_cc3_r    <= 1'b0;
    end else begin
      attn_pend_r <= kbd_break_in | (attn_pend_r & ~(ld_range & ~cmd_chan_in));
      st_attn_r   <= kbd_break_in | (st_attn_r & ~st_read);
      st_par_r    <= (rd_ev & par_err) | (st_par_r & ~st_read);
      st_cc2_r    <= ev_cancel | (st_cc2_r & ~ld_range);
      st_cc3_r    <= ev_home | (st_cc3_r & ~ld_range);
    end
  end

  a_id_readback: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd_valid_in && cmd_func_in == FC_DEV_ID |=> rsp_valid_out && rsp_data_out == DEV_ID)
    else $error("device id readback wrong");
  a_byte_addr_rd: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd_valid_in && cmd_func_in == FC_BYTE_ADDR |=> rsp_data_out == $past(addr_r[15:0]))
    else $error("byte address readback wrong");
  a_module_addr_rd: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd_valid_in && cmd_func_in == FC_MOD_ADDR |=> rsp_data_out == {8'h00, $past(addr_r[23:16])})
    else $error("module address readback wrong");
  a_indicator_busy: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    st_read |=> proc_indicator_out == $past(busy_out))
    else $error("indicator does not follow busy");
  a_read_start: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ld_range && !cmd_chan_in |=> busy_out && (state_r == S_RD_WAIT || state_r == S_RD_DMA))
    else $error("read order did not start");
  a_print_start: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ld_range && cmd_chan_in |=> busy_out && (state_r == S_WR_LF || state_r == S_WR_DMA))
    else $error("print order did not start");
  a_backspace_step: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ev_back && can_back && !ld_addr |=> addr_r == $past(addr_r) - 24'h00_0001 && range_r == $past(range_r) + 16'h0001)
    else $error("backspace did not step back");
  a_cancel_home: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ev_cancel |=> state_r == S_HOME ##0 st_cc2_r)
    else $error("line cancel did not terminate");
  a_home_then_idle: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_r == S_HOME && prt_fire |=> state_r == S_DONE ##1 !busy_out && state_r == S_IDLE)
    else $error("termination order wrong");
  a_paper_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    paper_tape_in |=> cfg_a_r == WORD_RST && cfg_b_r == WORD_RST)
    else $error("configuration not replaced");
  a_print_parity: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    prt_valid_out && !eight_bit |-> !(^prt_char_out))
    else $error("printed character parity odd");

  c_read_done: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_r == S_RD_ECHO ##[1:200] state_r == S_DONE);
  c_print_done: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_r == S_WR_PRT ##[1:200] state_r == S_DONE);
  c_backspace: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) ev_back && can_back);
  c_escape: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) ev_esc ##[1:50] ev_data);

endmodule : ctc_console_channel

// ---- pkg/ctc_pkg.sv ----
package ctc_pkg;

  // Function codes of input commands
  localparam logic [5:0]  FC_DEV_ID      = 6'h26;
  localparam logic [5:0]  FC_BYTE_ADDR   = 6'h08;
  localparam logic [5:0]  FC_MOD_ADDR    = 6'h0A;
  localparam logic [5:0]  FC_RANGE_IN    = 6'h0C;
  localparam logic [5:0]  FC_CFG_A_IN    = 6'h10;
  localparam logic [5:0]  FC_CFG_B_IN    = 6'h12;
  localparam logic [5:0]  FC_STATUS_IN   = 6'h18;
  // Function codes of output commands
  localparam logic [5:0]  FC_TASK_OUT    = 6'h07;
  localparam logic [5:0]  FC_CFG_A_OUT   = 6'h11;
  localparam logic [5:0]  FC_CFG_B_OUT   = 6'h13;
  localparam logic [5:0]  FC_ADDR_OUT    = 6'h09;
  localparam logic [5:0]  FC_RANGE_OUT   = 6'h0D;

  // Arbitrary identification value
  localparam logic [15:0] DEV_ID_DEFAULT = 16'h0C5A;

  // Task word fields, bit 0 is the least significant bit of the word
  localparam int          TB_ATTN_DISCARD = 10;
  localparam int          TB_ECHO         = 8;
  localparam int          TB_NO_CHECK     = 7;
  localparam int          TB_NO_HOME      = 6;
  localparam int          TB_EIGHT_BIT    = 5;
  localparam int          TB_LINES_LSB    = 0;

  // Status word fields
  localparam int          ST_ATTN         = 14;
  localparam int          ST_PARITY       = 12;
  localparam int          ST_TERM_CC2     = 7;
  localparam int          ST_TERM_CC3     = 6;

  // Reset values, characters and line length
  localparam logic [15:0] WORD_RST        = 16'h0000;
  localparam logic [23:0] ADDR_RST        = 24'h00_0000;
  localparam logic [7:0]  LF_CHAR         = 8'h0A;
  localparam logic [7:0]  CR_CHAR         = 8'h0D;
  localparam logic [7:0]  ATTN_CHAR       = 8'h00;
  localparam logic [6:0]  LINE_LEN        = 7'h48;

  typedef enum logic [8:0] {
    S_IDLE    = 9'b0_0000_0001,
    S_RD_WAIT = 9'b0_0000_0010,
    S_RD_DMA  = 9'b0_0000_0100,
    S_RD_ECHO = 9'b0_0000_1000,
    S_WR_LF   = 9'b0_0001_0000,
    S_WR_DMA  = 9'b0_0010_0000,
    S_WR_PRT  = 9'b0_0100_0000,
    S_HOME    = 9'b0_1000_0000,
    S_DONE    = 9'b1_0000_0000
  } ctc_state_type;

  function automatic logic [7:0] ctc_even_par(input logic [7:0] c);
    ctc_even_par = {^c[6:0], c[6:0]};
  endfunction : ctc_even_par

endpackage : ctc_pkg

// ---- logic/ctc_char_class.sv ----
`timescale 1ns/1ps
module ctc_char_class import ctc_pkg::*; (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       kbd_valid_in,
  input  wire logic [7:0] kbd_char_in,
  input  wire logic       seven_bit_in,
  input  wire logic       check_en_in,
  input  wire logic       escape_in,
  input  wire logic [7:0] cc1_in,
  input  wire logic [7:0] cc2_in,
  input  wire logic [7:0] cc3_in,
  input  wire logic [7:0] cc4_in,
  output logic            cls_valid_out,
  output logic [7:0]      cls_char_out,
  output logic            is_back_out,
  output logic            is_cancel_out,
  output logic            is_home_out,
  output logic            is_escape_out,
  output logic            parity_err_out
);

  // A control character of zero is unconfigured and never matches
  function automatic logic cc_hit(input logic [7:0] c, input logic [7:0] cc);
    cc_hit = (c == cc) && (cc != 8'h00);
  endfunction : cc_hit

  wire logic [7:0] char_w = seven_bit_in ? {1'b0, kbd_char_in[6:0]} : kbd_char_in;
  wire logic       chk_w  = check_en_in & ~escape_in;
  wire logic       par_w  = seven_bit_in & (^kbd_char_in);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cls_valid_out  <= 1'b0;
      cls_char_out   <= 8'h00;
      is_back_out    <= 1'b0;
      is_cancel_out  <= 1'b0;
      is_home_out    <= 1'b0;
      is_escape_out  <= 1'b0;
      parity_err_out <= 1'b0;
    end else begin
      cls_valid_out  <= kbd_valid_in;
      cls_char_out   <= char_w;
      is_back_out    <= chk_w & cc_hit(char_w, cc1_in);
      is_cancel_out  <= chk_w & cc_hit(char_w, cc2_in);
      is_home_out    <= chk_w & cc_hit(char_w, cc3_in);
      is_escape_out  <= chk_w & cc_hit(char_w, cc4_in);
      parity_err_out <= par_w;
    end
  end

endmodule : ctc_char_class

// ---- verif/ctc_console_model.sv ----
`timescale 1ns/1ps
module ctc_console_model #(
  parameter int DMA_LAT = 2,
  parameter int PRT_LAT = 3
) (
  input  wire logic        ref_clk_in,
  input  wire logic        dma_req_in,
  input  wire logic        dma_we_in,
  input  wire logic [23:0] dma_addr_in,
  input  wire logic [7:0]  dma_wdata_in,
  input  wire logic        prt_valid_in,
  input  wire logic [7:0]  prt_char_in,
  output logic             dma_ack_out,
  output logic [7:0]       dma_rdata_out,
  output logic             prt_ready_out
);
  logic [7:0] mem [0:255];
  logic [7:0] printed [$];
  int         dma_cnt = 0;
  int         prt_cnt = 0;

  initial begin
    dma_ack_out   = 1'b0;
    dma_rdata_out = 8'h5A;
    prt_ready_out = 1'b0;
  end

  // Rest two cycles after each answer so a request still standing is not served twice
  always @(posedge ref_clk_in) begin
    #1;
    if (dma_ack_out) dma_cnt = -2;
    dma_ack_out   = 1'b0;
    dma_rdata_out = ~dma_rdata_out;
    if (!dma_req_in) dma_cnt = (dma_cnt < 0) ? dma_cnt + 1 : 0;
    else if (dma_cnt < DMA_LAT) dma_cnt++;
    else begin
      dma_ack_out = 1'b1;
      if (dma_we_in) mem[dma_addr_in[7:0]] = dma_wdata_in;
      else dma_rdata_out = mem[dma_addr_in[7:0]];
    end
    // Slow printer: ready for one cycle after PRT_LAT cycles of a waiting character
    if (prt_ready_out) begin
      prt_ready_out = 1'b0;
      prt_cnt       = 0;
    end else if (prt_valid_in) begin
      prt_cnt++;
      if (prt_cnt >= PRT_LAT) prt_ready_out = 1'b1;
    end
  end

  always @(posedge ref_clk_in) begin
    if (prt_valid_in && prt_ready_out) printed.push_back(prt_char_in);
  end
endmodule : ctc_console_model

// ---- verif/ctc_console_channel_test.sv ----
`timescale 1ns/1ps
module ctc_console_channel_test import ctc_pkg::*;;
  localparam logic [15:0] ID = 16'h3E71; // Arbitrary identification value
  logic        ref_clk_in = 1'b0, rst_n_in = 1'b0, cmd_valid_in = 1'b0, cmd_chan_in = 1'b0;
  logic        paper_tape_in = 1'b0, int_allowed_in = 1'b1, kbd_valid_in = 1'b0, kbd_break_in = 1'b0;
  logic [5:0]  cmd_func_in = 6'h00;
  logic [23:0] cmd_data_in = 24'h00_0000;
  logic [7:0]  kbd_char_in = 8'h00;
  logic        rsp_valid_out, busy_out, proc_indicator_out, irq_out, prt_valid_out, prt_ready_in;
  logic        dma_req_out, dma_we_out, dma_ack_in;
  logic [15:0] rsp_data_out, r;
  logic [7:0]  prt_char_out, dma_rdata_in, dma_wdata_out;
  logic [23:0] dma_addr_out;
  int          failures = 0, total_checks = 0, irqs = 0;

  always #50 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (irq_out === 1'b1) irqs++;

  ctc_console_channel #(.DEV_ID(ID)) i_dut (.ref_clk_in, .rst_n_in, .cmd_valid_in, .cmd_func_in, .cmd_chan_in,
    .cmd_data_in, .paper_tape_in, .int_allowed_in, .kbd_valid_in, .kbd_char_in, .kbd_break_in, .prt_ready_in,
    .dma_ack_in, .dma_rdata_in, .rsp_valid_out, .rsp_data_out, .busy_out, .proc_indicator_out, .irq_out,
    .prt_valid_out, .prt_char_out, .dma_req_out, .dma_we_out, .dma_addr_out, .dma_wdata_out);
  ctc_console_model i_con (.ref_clk_in, .dma_req_in(dma_req_out), .dma_we_in(dma_we_out),
    .dma_addr_in(dma_addr_out), .dma_wdata_in(dma_wdata_out), .prt_valid_in(prt_valid_out),
    .prt_char_in(prt_char_out), .dma_ack_out(dma_ack_in), .dma_rdata_out(dma_rdata_in),
    .prt_ready_out(prt_ready_in));

  task close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Answer lands one cycle after the command is taken
  task automatic cmd(input logic [5:0] f, input logic c, input logic [23:0] d);
    @(posedge ref_clk_in);
    #1;
    cmd_valid_in = 1'b1;
    cmd_func_in  = f;
    cmd_chan_in  = c;
    cmd_data_in  = d;
    @(posedge ref_clk_in);
    #1;
    cmd_valid_in = 1'b0;
    r            = rsp_data_out;
    if (!f[0]) chk(rsp_valid_out, 1'b1);
  endtask : cmd

  // Operator typing pace, long enough for store and echo to finish
  task automatic key(input logic [7:0] c);
    @(posedge ref_clk_in);
    #1;
    kbd_valid_in = 1'b1;
    kbd_char_in  = c;
    @(posedge ref_clk_in);
    #1;
    kbd_valid_in = 1'b0;
    repeat (40) @(posedge ref_clk_in);
  endtask : key

  task automatic wait_idle;
    int n;
    for (n = 0; n < 2000 && busy_out !== 1'b0; n++) begin
      @(posedge ref_clk_in);
      #1;
    end
    if (n == 2000) begin
      chk(1'b1, 1'b0);
      close_out();
    end
    // One more edge so the interrupt pulse of the final cycle is counted
    @(posedge ref_clk_in);
    #1;
  endtask : wait_idle

  task automatic chk_prt(input logic [7:0] e[$]);
    chk(24'(i_con.printed.size()), 24'(e.size()));
    foreach (e[i]) chk(i_con.printed[i], e[i]);
    i_con.printed.delete();
  endtask : chk_prt

  task automatic load_cfg;
    cmd(FC_CFG_A_OUT, 1'b1, 24'h00_5F40);
    cmd(FC_CFG_B_OUT, 1'b1, 24'h00_0D5C);
  endtask : load_cfg

  initial begin
    repeat (10) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    chk({busy_out, rsp_valid_out, irq_out, dma_req_out, prt_valid_out}, 5'h00);
    cmd(FC_DEV_ID, 1'b0, 24'h00_0000); chk(r, ID);
    load_cfg();
    cmd(FC_CFG_A_IN, 1'b0, 24'h00_0000); chk(r, 16'h5F40);
    @(posedge ref_clk_in);
    #1;
    paper_tape_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    paper_tape_in = 1'b0;
    cmd(FC_CFG_B_IN, 1'b0, 24'h00_0000); chk(r, 16'h0000);
    load_cfg();
    i_con.mem[8'h40] = 8'h41;
    i_con.mem[8'h41] = 8'hC2;
    i_con.mem[8'h42] = 8'h43;
    cmd(FC_ADDR_OUT, 1'b1, 24'hA5_0040);
    cmd(FC_BYTE_ADDR, 1'b1, 24'h00_0000); chk(r, 16'h0040);
    cmd(FC_MOD_ADDR, 1'b1, 24'h00_0000); chk(r, 16'h00A5);
    // Print: two line feeds, three raw bytes, home character
    cmd(FC_TASK_OUT, 1'b1, 24'h00_0022);
    cmd(FC_RANGE_OUT, 1'b1, 24'h00_0003); chk(busy_out, 1'b1);
    wait_idle();
    chk_prt({8'h0A, 8'h0A, 8'h41, 8'hC2, 8'h43, 8'h0D});
    chk(irqs, 1);
    cmd(FC_STATUS_IN, 1'b1, 24'h00_0000); chk(proc_indicator_out, 1'b0);
    cmd(FC_ADDR_OUT, 1'b1, 24'h00_0041);
    cmd(FC_RANGE_OUT, 1'b1, 24'h00_0001);
    wait_idle();
    chk_prt({8'h0A, 8'h0A, 8'hC2, 8'h0D});
    // Read with echo and editing; range runs out on the escaped cancel character
    cmd(FC_TASK_OUT, 1'b0, 24'h00_0120);
    cmd(FC_ADDR_OUT, 1'b0, 24'h00_0080);
    cmd(FC_RANGE_OUT, 1'b0, 24'h00_0003); chk(busy_out, 1'b1);
    cmd(FC_STATUS_IN, 1'b0, 24'h00_0000); chk(proc_indicator_out, 1'b1);
    cmd(FC_ADDR_OUT, 1'b1, 24'h00_0000);
    key(8'h41);
    key(8'h42);
    key(8'h5F);
    key(8'h43);
    key(8'h5C);
    key(8'h40);
    wait_idle();
    chk(i_con.printed[0], 8'h41);
    chk(i_con.printed[$], 8'h0D);
    i_con.printed.delete();
    chk({i_con.mem[8'h80], i_con.mem[8'h81]}, 16'h4143);
    chk(i_con.mem[8'h82], 8'h40);
    cmd(FC_STATUS_IN, 1'b0, 24'h00_0000);
    cmd(FC_RANGE_IN, 1'b0, 24'h00_0000); chk(r, 16'h0000);
    cmd(FC_BYTE_ADDR, 1'b0, 24'h00_0000); chk(r, 16'h0083);
    chk(irqs, 3);
    // Seven-bit read ended by the cancel character
    cmd(FC_TASK_OUT, 1'b0, 24'h00_0100);
    cmd(FC_ADDR_OUT, 1'b0, 24'h00_0090);
    cmd(FC_RANGE_OUT, 1'b0, 24'h00_0005);
    key(8'hC1);
    key(8'h40);
    wait_idle();
    chk(i_con.printed[0], 8'h41);
    chk(i_con.printed[1], 8'h8D);
    i_con.printed.delete();
    cmd(FC_STATUS_IN, 1'b0, 24'h00_0000); chk(r[ST_TERM_CC2], 1'b1);
    chk(r[ST_PARITY], 1'b1);
    cmd(FC_RANGE_IN, 1'b0, 24'h00_0000); chk(r, 16'h0004);
    // Checking off with attention pending: attention byte leads, cancel character stored plainly
    @(posedge ref_clk_in);
    #1;
    kbd_break_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    kbd_break_in = 1'b0;
    cmd(FC_TASK_OUT, 1'b0, 24'h00_00A0);
    cmd(FC_ADDR_OUT, 1'b0, 24'h00_00A0);
    cmd(FC_RANGE_OUT, 1'b0, 24'h00_0002);
    // Let the attention byte reach memory before the operator types
    repeat (10) @(posedge ref_clk_in);
    key(8'h40);
    wait_idle();
    chk(i_con.mem[8'hA0], ATTN_CHAR);
    chk(i_con.mem[8'hA1], 8'h40);
    cmd(FC_STATUS_IN, 1'b0, 24'h00_0000); chk(r[ST_ATTN], 1'b1);
    chk(busy_out, 1'b0);
    // Long line with no return and no home character: bytes past column 72 are fetched, not printed
    for (int i = 0; i < 32'h0000_004A; i++) i_con.mem[i] = 8'h41;
    i_con.printed.delete();
    cmd(FC_TASK_OUT, 1'b1, 24'h00_0060);
    cmd(FC_ADDR_OUT, 1'b1, 24'h00_0000);
    cmd(FC_RANGE_OUT, 1'b1, 24'h00_004A);
    wait_idle();
    chk(24'(i_con.printed.size()), 24'h00_0048);
    chk(i_con.printed[71], 8'h41);
    cmd(FC_BYTE_ADDR, 1'b1, 24'h00_0000); chk(r, 16'h004A);
    close_out();
  end
endmodule : ctc_console_channel_test
